// [common/ttd_map.vh]
// Purpose: register offsets, field layout, codes and defaults of the telegram watchdog
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef TTD_MAP_VH
`define TTD_MAP_VH

// =====================================================================
// Register byte offsets
`define TTD_OFF_CTRL      8'h00
`define TTD_OFF_WMAX      8'h04
`define TTD_OFF_CPL       8'h08
`define TTD_OFF_LINK      8'h0c
`define TTD_OFF_LATE      8'h10

// =====================================================================
// Control fields
`define TTD_CTRL_UDP_BIT  0
`define TTD_CTRL_CLR_BIT  1

// =====================================================================
// Status codes
`define TTD_CPL_OK        16'h0000
`define TTD_CPL_BUSFLT    16'h0001
`define TTD_CPL_CFGFLT    16'h0002
`define TTD_LINK_OK       8'h00
`define TTD_LINK_STALE    8'h01
`define TTD_LINK_ZERO     8'h02

// =====================================================================
// Defaults and bus answers
`define TTD_WMAX_DEF      8'h64
`define TTD_RESP_OKAY     2'b00
`define TTD_RESP_SLVERR   2'b10

`endif

// [src/ttd_supervisor.v]
// Purpose: per-period bookkeeping of late replies, warning level and output zeroing
// Assumes: period_tick and reply_ok are one-cycle pulses on clk_sys
// Notes: instantiated by ttd_watchdog
`timescale 1ns/1ps
`include "ttd_map.vh"

module ttd_supervisor #(
    parameter CNT_W = 16,
    parameter LVL_W = 8
) (
    input  wire             clk_sys,
    input  wire             sys_rst,
    input  wire             period_tick,
    input  wire             reply_ok,
    input  wire             udp_mode,
    input  wire             clear_cnt,
    input  wire [LVL_W-1:0] warn_max,
    output reg  [CNT_W-1:0] late_telegram_count,
    output reg  [LVL_W-1:0] warn_level,
    output reg              reply_seen,
    output reg              inputs_stale,
    output reg              outputs_zeroed
);

    // =================================================================
    // Period bookkeeping
    reg             next_seen;
    reg [LVL_W-1:0] next_level;
    reg             next_zero;
    reg             period_open;
    wire            closing;
    wire            got_reply;

    // First tick after reset only opens a period: nothing was sent before it
    assign closing   = period_tick & period_open;
    assign got_reply = reply_seen | reply_ok;

    // Reply in same cycle as tick belongs to the period now ending
    always @* begin
        next_seen  = reply_seen | reply_ok;
        next_level = warn_level;
        next_zero  = outputs_zeroed;
        if (period_tick) begin
            next_seen = 1'b0;
            if (closing && udp_mode && !got_reply) begin
                if (warn_level < warn_max) begin
                    next_level = warn_level + {{(LVL_W-1){1'b0}}, 1'b1};
                end
            end else if (closing && udp_mode && warn_level != {LVL_W{1'b0}}) begin
                next_level = warn_level - {{(LVL_W-1){1'b0}}, 1'b1};
            end
        end
        if (!udp_mode) begin
            next_level = {LVL_W{1'b0}};
            next_zero  = 1'b0;
        end else if (next_level >= warn_max) begin
            next_zero = 1'b1;
        end else if (next_level == {LVL_W{1'b0}}) begin
            next_zero = 1'b0;
        end
    end

    // Counter wraps rather than saturates, software reads differences
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            late_telegram_count <= {CNT_W{1'b0}};
            warn_level          <= {LVL_W{1'b0}};
            reply_seen          <= 1'b0;
            inputs_stale        <= 1'b0;
            outputs_zeroed      <= 1'b0;
            period_open         <= 1'b0;
        end else begin
            reply_seen     <= next_seen;
            warn_level     <= next_level;
            outputs_zeroed <= next_zero;
            period_open    <= period_open | period_tick;
            if (closing && !got_reply) begin
                late_telegram_count <= late_telegram_count
                                       + {{(CNT_W-1){1'b0}}, 1'b1};
                inputs_stale <= 1'b1;
            end else if (clear_cnt) begin
                late_telegram_count <= {CNT_W{1'b0}};
            end
            if (closing && got_reply) begin
                inputs_stale <= 1'b0;
            end
        end
    end

endmodule

// [src/ttd_watchdog.v]
// Purpose: telegram timeout diagnostics with AXI4-Lite register access
// Assumes: one task-period tick per period, reply pulses from the link side
// Notes: output data zeroing applied to a parallel process image word
`timescale 1ns/1ps
`include "ttd_map.vh"

module ttd_watchdog #(
    parameter DATA_W = 32,
    parameter CNT_W  = 16,
    parameter LVL_W  = 8
) (
    input  wire              clk_sys,
    input  wire              sys_rst,
    input  wire              period_tick,
    input  wire              reply_ok,
    input  wire              tbus_fault,
    input  wire              cfg_mismatch,
    input  wire [DATA_W-1:0] out_data,
    output reg  [DATA_W-1:0] out_data_gated,
    output reg               inputs_stale,
    input  wire [7:0]        s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [7:0]        s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready
);

    // =================================================================
    // Decode helper, used by both read and write paths
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `TTD_OFF_CTRL) || (a == `TTD_OFF_WMAX) ||
                     (a == `TTD_OFF_CPL)  || (a == `TTD_OFF_LINK) ||
                     (a == `TTD_OFF_LATE);
        end
    endfunction

    // =================================================================
    // Software-steered control
    reg             udp_mode;
    reg             clear_cnt;
    reg [LVL_W-1:0] warn_max;

    wire [CNT_W-1:0] late_telegram_count;
    wire [LVL_W-1:0] warn_level;
    wire             stale_int;
    wire             outputs_zeroed;
    reg  [15:0]      coupler_status;
    reg  [15:0]      link_health_code;

    ttd_supervisor #(
        .CNT_W (CNT_W),
        .LVL_W (LVL_W)
    ) u_sup (
        .clk_sys             (clk_sys),
        .sys_rst             (sys_rst),
        .period_tick         (period_tick),
        .reply_ok            (reply_ok),
        .udp_mode            (udp_mode),
        .clear_cnt           (clear_cnt),
        .warn_max            (warn_max),
        .late_telegram_count (late_telegram_count),
        .warn_level          (warn_level),
        .reply_seen          (),
        .inputs_stale        (stale_int),
        .outputs_zeroed      (outputs_zeroed)
    );

    // =================================================================
    // Status codes; bus fault takes priority over config mismatch
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            coupler_status   <= `TTD_CPL_OK;
            link_health_code <= 16'h0000;
            out_data_gated   <= {DATA_W{1'b0}};
            inputs_stale     <= 1'b0;
        end else begin
            if (tbus_fault) begin
                coupler_status <= `TTD_CPL_BUSFLT;
            end else if (cfg_mismatch) begin
                coupler_status <= `TTD_CPL_CFGFLT;
            end else begin
                coupler_status <= `TTD_CPL_OK;
            end
            if (!udp_mode) begin
                link_health_code <= {8'h00,
                    stale_int ? `TTD_LINK_STALE : `TTD_LINK_OK};
            end else begin
                link_health_code <= {warn_level,
                    outputs_zeroed ? `TTD_LINK_ZERO :
                    (stale_int ? `TTD_LINK_STALE : `TTD_LINK_OK)};
            end
            out_data_gated <= outputs_zeroed ? {DATA_W{1'b0}} : out_data;
            inputs_stale   <= stale_int;
        end
    end

    // =================================================================
    // AXI4-Lite write path: address and data accepted in either order
    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TTD_RESP_OKAY;
            udp_mode      <= 1'b0;
            clear_cnt     <= 1'b0;
            warn_max      <= `TTD_WMAX_DEF;
        end else begin
            clear_cnt     <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Commit once both halves are held
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr) ? `TTD_RESP_OKAY : `TTD_RESP_SLVERR;
                if (aw_addr == `TTD_OFF_CTRL && w_strb[0]) begin
                    udp_mode  <= w_data[`TTD_CTRL_UDP_BIT];
                    clear_cnt <= w_data[`TTD_CTRL_CLR_BIT];
                end
                if (aw_addr == `TTD_OFF_WMAX && w_strb[0] && w_data[7:0] != 8'h00) begin
                    warn_max <= w_data[LVL_W-1:0];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =================================================================
    // AXI4-Lite read path: one read in flight, data registered
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TTD_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= mapped(s_axi_araddr) ? `TTD_RESP_OKAY : `TTD_RESP_SLVERR;
                case (s_axi_araddr)
                    `TTD_OFF_CTRL: s_axi_rdata <= {31'h0000_0000, udp_mode};
                    `TTD_OFF_WMAX: s_axi_rdata <= {24'h00_0000, warn_max};
                    `TTD_OFF_CPL:  s_axi_rdata <= {16'h0000, coupler_status};
                    `TTD_OFF_LINK: s_axi_rdata <= {16'h0000, link_health_code};
                    `TTD_OFF_LATE: s_axi_rdata <= {16'h0000, late_telegram_count};
                    default:       s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// [test/ttd_watchdog_properties.sv]
// Purpose: port checks of the telegram watchdog
// Assumes: a reply in the cycle of a tick belongs to the period that the tick closes
// Notes: bound after the module
`timescale 1ns/1ps
module ttd_watchdog_chk #(parameter DATA_W = 32) (
    input wire              clk_sys,
    input wire              sys_rst,
    input wire              period_tick,
    input wire              reply_ok,
    input wire [DATA_W-1:0] out_data,
    input wire [DATA_W-1:0] out_data_gated,
    input wire              inputs_stale,
    input wire              s_axi_awready,
    input wire              s_axi_wready,
    input wire              s_axi_bvalid,
    input wire              s_axi_bready,
    input wire [1:0]        s_axi_bresp,
    input wire              s_axi_arvalid,
    input wire              s_axi_arready,
    input wire              s_axi_rvalid,
    input wire              s_axi_rready,
    input wire [31:0]       s_axi_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // =====================================================================
    // Reply seen since the last tick; cleared by the tick itself
    // First tick after reset only opens a period and judges nothing
    reg seen;
    reg opened;
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            seen   <= 1'b0;
            opened <= 1'b0;
        end else begin
            seen   <= period_tick ? 1'b0 : (seen | reply_ok);
            opened <= opened | period_tick;
        end
    end
    stale_on_miss_a: assert property (period_tick && opened && !(seen || reply_ok)
        |-> ##2 inputs_stale) else $error("stale flag missing after late reply");
    fresh_on_reply_a: assert property (period_tick && opened && (seen || reply_ok)
        |-> ##2 !inputs_stale) else $error("stale flag set after timely reply");
    stale_holds_a: assert property (!$past(period_tick, 2) |-> $stable(inputs_stale))
        else $error("stale flag moved without a tick");
    gate_value_a: assert property (out_data_gated == 0
        || out_data_gated == $past(out_data))
        else $error("gated output is neither data nor zero");
    bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read response dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    no_aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    no_ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while response pending");
    cover property (period_tick && !seen);
    cover property (period_tick && seen);
    cover property (out_data_gated == 0 && out_data != 0);
endmodule
bind ttd_watchdog ttd_watchdog_chk #(.DATA_W(DATA_W)) u_chk (.*);

// [test/ttd_master_model.sv]
// Purpose: cyclic master sending one telegram per period
// Assumes: start pulses only while idle
// Notes: late periods get no reply at all
`timescale 1ns/1ps
module ttd_master_model #(parameter PER = 24) (
    input  wire       clk_sys,
    input  wire       sys_rst,
    input  wire       start,
    input  wire       late,
    input  wire [2:0] dly,
    output reg        period_tick,
    output reg        reply_ok,
    output reg        busy
);
    reg [7:0] cnt;
    // =====================================================================
    // Short period in cycles; stands in for the long recommended one
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            period_tick <= 1'b0;
            reply_ok    <= 1'b0;
            busy        <= 1'b0;
            cnt         <= 8'h00;
        end else begin
            period_tick <= start && !busy; // Telegram as the period opens
            reply_ok    <= busy && !late && (cnt == PER - dly); // Same period
            if (start && !busy) begin
                busy <= 1'b1;
                cnt  <= PER;
            end else if (cnt != 0) cnt <= cnt - 8'h01;
            else busy <= 1'b0;
        end
    end
endmodule

// [test/telegram_timeout_diagnostics_tb_top.sv]
// Purpose: self-checking bench of the telegram watchdog
// Assumes: registers read between periods only
// Notes: expectations kept in bench state
`timescale 1ns/1ps
`include "ttd_map.vh"
`define CHK(nm, e, a) begin num_checks = num_checks + 1; if ((e) !== (a)) begin \
    err_count = err_count + 1; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module telegram_timeout_diagnostics_tb_top;
    reg clk_sys = 1'b0, sys_rst = 1'b1, tbus_fault = 1'b0, cfg_mismatch = 1'b0;
    reg [31:0] out_data = 32'h0, s_axi_wdata = 32'h0, rd;
    reg [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lvl, wmax;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, start = 1'b0, late = 1'b0;
    reg [2:0] dly = 3'h1;
    reg [1:0] rs, rb;
    reg [15:0] cnt;
    reg udp, zer, stl, prev_late;
    wire period_tick, reply_ok, busy, inputs_stale, s_axi_awready, s_axi_wready;
    wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [31:0] out_data_gated, s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    integer seed, err_count, num_checks, i;
    always #2.5 clk_sys = ~clk_sys;
    ttd_watchdog u_ttd_watchdog (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .period_tick(period_tick), .reply_ok(reply_ok), .tbus_fault(tbus_fault),
        .cfg_mismatch(cfg_mismatch), .out_data(out_data), .out_data_gated(out_data_gated),
        .inputs_stale(inputs_stale), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    ttd_master_model u_ttd_master_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start),
        .late(late), .dly(dly), .period_tick(period_tick), .reply_ok(reply_ok), .busy(busy));
    // =====================================================================
    // Expected link code from the bench state
    function [15:0] exp_link(input dummy);
        exp_link = udp ? {lvl, zer ? 8'h02 : {7'h00, stl}} : {15'h0000, stl};
    endfunction
    task results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task timeout;
        err_count = err_count + 1;
        $display("[ERR] wait exp done got timeout");
        results;
    endtask
    // Both channels offered together, each released once taken
    task axw(input [7:0] a, input [31:0] d);
        reg fin;
        begin
            fin = 1'b0;
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            for (i = 0; i < 50 && !fin; i = i + 1) begin
                @(posedge clk_sys);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) begin
                    fin = 1'b1;
                    rb = s_axi_bresp;
                end
            end
            // Ready stays up: dropping it here double-drives back-to-back calls
            if (!fin) timeout;
        end
    endtask
    task axr(input [7:0] a);
        reg fin;
        begin
            fin = 1'b0;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            for (i = 0; i < 50 && !fin; i = i + 1) begin
                @(posedge clk_sys);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) begin
                    fin = 1'b1;
                    rd = s_axi_rdata;
                    rs = s_axi_rresp;
                end
            end
            if (!fin) timeout;
        end
    endtask
    // One period; its tick judges the period before it
    task per(input lt);
        begin
            if (prev_late) begin
                cnt = cnt + 16'h0001;
                stl = 1'b1;
                if (udp && lvl < wmax) lvl = lvl + 8'h01;
            end else begin
                stl = 1'b0;
                if (udp && lvl != 0) lvl = lvl - 8'h01;
            end
            if (udp && lvl >= wmax) zer = 1'b1;
            if (lvl == 0) zer = 1'b0;
            prev_late = lt;
            late <= lt;
            dly <= 3'h1 + ($random(seed) & 3'h3);
            out_data <= $random(seed);
            start <= 1'b1;
            @(posedge clk_sys);
            start <= 1'b0;
            @(posedge clk_sys);
            for (i = 0; i < 100 && busy; i = i + 1) @(posedge clk_sys);
            if (busy) timeout;
            axr(`TTD_OFF_LATE);
            `CHK("late", {16'h0000, cnt}, rd)
            axr(`TTD_OFF_LINK);
            `CHK("link", {16'h0000, exp_link(1'b0)}, rd)
            `CHK("stale", stl, inputs_stale)
            `CHK("gate", zer ? 32'h0 : out_data, out_data_gated)
        end
    endtask
    initial begin
        seed = 32'hb45f;
        err_count = 0;
        num_checks = 0;
        // No period before the first tick, so nothing counts as late there
        {udp, zer, stl, prev_late, lvl, wmax, cnt} = {4'b0000, 8'h00, `TTD_WMAX_DEF, 16'h0};
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        axr(`TTD_OFF_WMAX);
        `CHK("wmax", {24'h0, `TTD_WMAX_DEF}, rd)
        `CHK("rresp", `TTD_RESP_OKAY, rs)
        axr(8'h3c);
        `CHK("unmapped", `TTD_RESP_SLVERR, rs)
        while (num_checks < 6) begin
            tbus_fault <= num_checks[0];
            cfg_mismatch <= num_checks[1];
            repeat (2) @(posedge clk_sys);
            axr(`TTD_OFF_CPL);
            `CHK("cpl", tbus_fault ? 32'h1 : {30'h0, cfg_mismatch, 1'b0}, rd)
        end
        $display("test coupler done");
        repeat (12) per($random(seed) & 1);
        axw(`TTD_OFF_CTRL, 32'h2);
        cnt = 16'h0000;
        axr(`TTD_OFF_LATE);
        `CHK("clear", 32'h0, rd)
        $display("test tcp done");
        axw(`TTD_OFF_WMAX, 32'h3);
        `CHK("bresp", `TTD_RESP_OKAY, rb)
        axw(`TTD_OFF_WMAX, 32'h0);
        axw(8'h3c, 32'h0);
        `CHK("bresp_unmapped", `TTD_RESP_SLVERR, rb)
        axr(`TTD_OFF_WMAX);
        `CHK("wmax_keep", 32'h3, rd)
        axw(`TTD_OFF_CTRL, 32'h1);
        {udp, wmax} = {1'b1, 8'h03};
        axr(`TTD_OFF_CTRL);
        `CHK("ctrl", 32'h1, rd)
        repeat (5) per(1'b1);
        repeat (5) per(1'b0);
        repeat (6) per($random(seed) & 1);
        $display("test udp done");
        results;
    end
endmodule
